// ### design/rsm_regs.svh
// Constants for the range sample and motor channel block
`ifndef RSM_REGS_SVH
`define RSM_REGS_SVH
`define RSM_CLK_HZ          25000000
`define RSM_TIMING_HZ       80000000
`define RSM_MAX_PERIOD_MS   32
`define RSM_MAX_PERIOD_CYC  ((`RSM_CLK_HZ / 1000) * `RSM_MAX_PERIOD_MS)
`define RSM_MIN_PERIOD_US   20
`define RSM_MIN_PERIOD_CYC  ((`RSM_CLK_HZ / 1000000) * `RSM_MIN_PERIOD_US)
`define RSM_RANGE_W         19
`define RSM_POWER_LEVELS    64
`define RSM_PWM_HZ          20000
`define RSM_PWM_CYC         (`RSM_CLK_HZ / `RSM_PWM_HZ)
`define RSM_FIFO_DEPTH      8
`define RSM_POWER_IDLE      6'h00
`endif

// ### design/rsm_pkg.sv
// Types for the range sample and motor channel block
package rsm_pkg;
   // One eight byte sample
   typedef struct packed {
      logic [18:0] range_count;
      logic [4:0]  status;
      logic [7:0]  strength;
      logic [7:0]  ambient;
      logic [7:0]  temperature;
      logic [7:0]  pos_motor1;
      logic [7:0]  pos_motor2;
   } rsm_sample_t;
   // Signed power command: magnitude plus reverse
   typedef struct packed {
      logic       reverse;
      logic [5:0] level;
   } rsm_power_t;
   typedef enum logic [1:0] {
      RSM_IDLE  = 2'b00,
      RSM_HIGH  = 2'b01,
      RSM_DONE  = 2'b10
   } rsm_state_t;
endpackage

// ### design/rsm_fifo.sv
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rsm_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8
) (
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   output logic [WIDTH-1:0]      rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      count;
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      next_count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic             push;
   logic             pop;
   // Handshakes
   assign push = wr_valid_in && wr_ready_out;
   assign pop  = rd_valid_out && rd_ready_in;
   assign wr_ready_out = (count != (AW+1)'(DEPTH));
   assign rd_valid_out = (count != '0);
   assign rd_data_out  = mem[rd_ptr];
   // Pointer and count update
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end
   // State registers
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end
   // Storage
   always_ff @(posedge clock_in) begin
      if (push) begin
         mem[wr_ptr] <= wr_data_in;
      end
   end
endmodule // rsm_fifo

// ### design/rsm_top.sv
// Range pulse sampler with motor power and encoder channels
// What this block does
// - One sample per received range pulse
// - Sensor link is receive only
// - Sustain 50,000 samples per second without loss
// - Two motors, 64 power levels each
// - 8-bit wrapping encoder positions in every sample
// - Latched index inputs appear in samples
// - PWM drive reverses by command; voltage drive none
// - Small variant: voltage drive only
// - Pulse width counted in timing clock ticks
// - Eight byte sample: 19-bit range plus bytes
// - Start/stop gates sampling; finish current sample
// - Every quadrature edge counts up or down
`timescale 1ns/1ps
`include "rsm_regs.svh"
module rsm_top #(
   parameter bit PWM_OPTION = 1'b1,
   parameter int PWM_CYC    = `RSM_PWM_CYC
) (
   input  wire logic                  clock_in,
   input  wire logic                  rst_in,
   input  wire logic                  range_pulse_in,
   input  wire logic                  start_in,
   input  wire logic [2:0]            gp_in,
   input  wire logic [1:0]            enc_a_in,
   input  wire logic [1:0]            enc_b_in,
   input  wire logic [23:0]           analog_in,
   input  wire rsm_pkg::rsm_power_t   power1_in,
   input  wire rsm_pkg::rsm_power_t   power2_in,
   input  wire logic                  power_wr_in,
   input  wire logic                  sample_ready_in,
   output rsm_pkg::rsm_sample_t       sample_out,
   output logic                       sample_valid_out,
   output logic [1:0]                 motor_pwm_out,
   output logic [1:0]                 motor_rev_out,
   output logic [5:0]                 motor1_level_out,
   output logic [5:0]                 motor2_level_out,
   output logic                       overflow_out
);
   import rsm_pkg::*;
   // Pin synchronisers: two flops before any logic
   logic [8:0] sync1;
   logic [8:0] sync2;
   logic [8:0] pins;
   assign pins = {range_pulse_in, start_in, gp_in, enc_a_in, enc_b_in};
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end
   logic       pulse_s;
   logic       start_s;
   logic [2:0] gp_s;
   logic [1:0] a_s;
   logic [1:0] b_s;
   assign {pulse_s, start_s, gp_s, a_s, b_s} = sync2;

   // Pulse width timer state
   rsm_state_t  state;
   rsm_state_t  next_state;
   logic [18:0] width;
   logic [18:0] next_width;
   logic        armed;
   logic        next_armed;
   logic        push;
   logic        fifo_ready;
   // The count steps by the integer part of the timing-to-system clock ratio per cycle
   localparam logic [18:0] STEP = 19'(`RSM_TIMING_HZ / `RSM_CLK_HZ);
   localparam logic [24:0] REM  = 25'(`RSM_TIMING_HZ % `RSM_CLK_HZ);
   localparam logic [24:0] CLKV = 25'(`RSM_CLK_HZ);
   logic [24:0] acc;
   logic [24:0] next_acc;
   logic        carry;
   logic [18:0] step_now;
   // The remainder accumulates so the fractional tick is never lost
   always_comb begin
      next_state = state;
      next_width = width;
      next_armed = armed;
      next_acc   = acc;
      push       = 1'b0;
      carry      = (acc + REM) >= CLKV;
      step_now   = carry ? STEP + 19'h1 : STEP;
      unique case (state)
         RSM_IDLE: begin
            if (pulse_s) begin
               next_state = RSM_HIGH;
               next_width = '0;
               next_acc   = '0;
               next_armed = start_s && fifo_ready;
            end
         end
         RSM_HIGH: begin
            next_acc = carry ? acc + REM - CLKV : acc + REM;
            if (width > ~step_now) begin
               next_width = '1; // Saturate, never wrap
            end else begin
               next_width = width + step_now;
            end
            if (!pulse_s) begin
               next_state = RSM_DONE;
            end
         end
         RSM_DONE: begin
            push       = armed; // Finish a started sample
            next_state = RSM_IDLE;
         end
         default: next_state = RSM_IDLE;
      endcase
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state <= RSM_IDLE;
         width <= '0;
         armed <= 1'b0;
         acc   <= '0;
      end else begin
         state <= next_state;
         width <= next_width;
         armed <= next_armed;
         acc   <= next_acc;
      end
   end

   // Quadrature decode, four counts per cycle
   function automatic logic [7:0] quad_step(input logic [1:0] prev,
                                            input logic [1:0] cur,
                                            input logic [7:0] pos);
      logic dir;
      dir = prev[1] ^ cur[0];
      if (prev == cur || (prev ^ cur) == 2'b11) begin
         quad_step = pos;
      end else begin
         quad_step = dir ? pos - 8'h01 : pos + 8'h01;
      end
   endfunction
   logic [1:0] prev_ab [2];
   logic [7:0] pos [2];
   logic [7:0] next_pos [2];
   logic [1:0] idx;
   logic [1:0] next_idx;
   always_comb begin
      for (int m = 0; m < 2; m++) begin
         next_pos[m] = quad_step(prev_ab[m], {a_s[m], b_s[m]},
                                 pos[m]);
      end
      // Index levels stay latched until a sample is taken
      next_idx = (push ? 2'b00 : idx) | gp_s[1:0];
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         prev_ab <= '{2'b00, 2'b00};
         pos     <= '{8'h00, 8'h00};
         idx     <= '0;
      end else begin
         prev_ab <= '{{a_s[0], b_s[0]}, {a_s[1], b_s[1]}};
         pos     <= next_pos;
         idx     <= next_idx;
      end
   end

   // Sample assembly; gp3 is inverted and not latched
   rsm_sample_t smp;
   logic        overflow;
   logic        next_overflow;
   always_comb begin
      smp.range_count = width;
      smp.status      = {overflow, ~gp_s[2], idx[1] | gp_s[1],
                         idx[0] | gp_s[0], start_s};
      smp.strength    = analog_in[23:16];
      smp.ambient     = analog_in[15:8];
      smp.temperature = analog_in[7:0];
      smp.pos_motor1  = pos[0];
      smp.pos_motor2  = pos[1];
      next_overflow   = overflow | (pulse_s && state == RSM_IDLE
                                    && start_s && !fifo_ready);
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         overflow <= 1'b0;
      end else begin
         overflow <= next_overflow;
      end
   end

   // Sample buffer; drains toward the host
   rsm_sample_t fifo_data;
   logic        fifo_valid;
   rsm_fifo #(
      .WIDTH ($bits(rsm_sample_t)),
      .DEPTH (`RSM_FIFO_DEPTH)
   ) u_fifo (
      .clock_in     (clock_in),
      .rst_in       (rst_in),
      .wr_data_in   (smp),
      .wr_valid_in  (push),
      .wr_ready_out (fifo_ready),
      .rd_data_out  (fifo_data),
      .rd_valid_out (fifo_valid),
      .rd_ready_in  (sample_ready_in)
   );
   // Output stage fed from the FIFO head, one cycle behind
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sample_out       <= '0;
         sample_valid_out <= 1'b0;
         overflow_out     <= 1'b0;
      end else begin
         sample_out       <= fifo_data;
         sample_valid_out <= fifo_valid && !sample_ready_in;
         overflow_out     <= overflow;
      end
   end

   // Motor power, 64 levels; no-drive after reset
   rsm_power_t pw [2];
   rsm_power_t next_pw [2];
   logic [15:0] pwm_cnt;
   logic [15:0] next_pwm_cnt;
   logic [1:0]  next_pwm;
   logic [1:0]  next_rev;
   always_comb begin
      next_pw = pw;
      if (power_wr_in) begin
         next_pw[0] = power1_in;
         next_pw[1] = power2_in;
      end
      next_pwm_cnt = (pwm_cnt >= 16'(PWM_CYC - 1)) ? '0 : pwm_cnt + 16'h1;
      for (int m = 0; m < 2; m++) begin
         // Duty is level over 64 of the PWM period
         next_pwm[m] = PWM_OPTION &&
                       (32'(pwm_cnt) * `RSM_POWER_LEVELS <
                        32'(pw[m].level) * PWM_CYC);
         next_rev[m] = PWM_OPTION && pw[m].reverse;
      end
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         pw               <= '{'{1'b0, `RSM_POWER_IDLE},
                               '{1'b0, `RSM_POWER_IDLE}};
         pwm_cnt          <= '0;
         motor_pwm_out    <= '0;
         motor_rev_out    <= '0;
         motor1_level_out <= `RSM_POWER_IDLE;
         motor2_level_out <= `RSM_POWER_IDLE;
      end else begin
         pw               <= next_pw;
         pwm_cnt          <= next_pwm_cnt;
         motor_pwm_out    <= next_pwm;
         motor_rev_out    <= next_rev;
         motor1_level_out <= pw[0].level;
         motor2_level_out <= pw[1].level;
      end
   end
   // No output reaches the sensor: the link is receive only
endmodule // rsm_top

// ### test/rsm_top_checker.sv
// Port checker for the range sampler and motor channel block
`timescale 1ns/1ps
module rsm_top_checker #(
   parameter bit PWM_OPTION = 1'b1
) (
   input wire logic               clock_in,
   input wire logic               rst_in,
   input wire rsm_pkg::rsm_power_t power1_in,
   input wire rsm_pkg::rsm_power_t power2_in,
   input wire logic               power_wr_in,
   input wire logic               sample_ready_in,
   input wire logic               sample_valid_out,
   input wire logic [1:0]         motor_pwm_out,
   input wire logic [1:0]         motor_rev_out,
   input wire logic [5:0]         motor1_level_out,
   input wire logic [5:0]         motor2_level_out,
   input wire logic               overflow_out
);
   import rsm_pkg::*;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // Reverse command to motor 1 on a drive that allows it
   sequence s_rev1;
      power_wr_in && power1_in.reverse && PWM_OPTION;
   endsequence
   a_level_idle: assert property (
      $fell(rst_in) |-> motor1_level_out == 6'h00 && motor2_level_out == 6'h00)
      else $error("motor level not idle after reset");
   a_level1_take: assert property (
      power_wr_in |-> ##2 motor1_level_out == $past(power1_in.level, 2))
      else $error("motor 1 level not taken");
   a_level2_take: assert property (
      power_wr_in |-> ##2 motor2_level_out == $past(power2_in.level, 2))
      else $error("motor 2 level not taken");
   a_level_hold: assert property (
      !$past(power_wr_in) |=> $stable({motor1_level_out, motor2_level_out}))
      else $error("motor level moved without a write");
   a_valid_pop: assert property (
      sample_ready_in |=> !sample_valid_out)
      else $error("sample valid kept across a pop");
   a_overflow_sticky: assert property (
      overflow_out |=> overflow_out)
      else $error("overflow flag dropped");
   a_pwm_variant: assert property (
      !PWM_OPTION |-> motor_pwm_out == 2'b00)
      else $error("pulse drive active on voltage variant");
   a_rev_variant: assert property (
      !PWM_OPTION |-> motor_rev_out == 2'b00)
      else $error("reverse active on voltage variant");
   a_rev_take: assert property (
      s_rev1 |=> ##[0:70] motor_rev_out[0])
      else $error("motor 1 reverse not applied");
endmodule // rsm_top_checker

bind rsm_top rsm_top_checker #(.PWM_OPTION(PWM_OPTION)) rsm_top_checker_inst (
   .clock_in(clock_in), .rst_in(rst_in), .power1_in(power1_in),
   .power2_in(power2_in), .power_wr_in(power_wr_in),
   .sample_ready_in(sample_ready_in), .sample_valid_out(sample_valid_out),
   .motor_pwm_out(motor_pwm_out), .motor_rev_out(motor_rev_out),
   .motor1_level_out(motor1_level_out), .motor2_level_out(motor2_level_out),
   .overflow_out(overflow_out));

// ### test/rsm_sensor_model.sv
// Behavioural rangefinder pulse-width source
`timescale 1ns/1ps
module rsm_sensor_model (
   input  wire logic clock_in,
   output logic      pulse_out
);
   // One-way link: nothing comes back from the card
   initial pulse_out = 1'b0;
   // One pulse, then idle low for the rest of the period
   task automatic fire(input int width, input int period);
      @(posedge clock_in);
      pulse_out <= 1'b1;
      repeat (width) @(posedge clock_in);
      pulse_out <= 1'b0;
      repeat (period - width) @(posedge clock_in);
   endtask
endmodule // rsm_sensor_model

// ### test/test_range_sample_and_motor_channels.sv
// Self-checking bench for the range sampler and motor channels
`timescale 1ns/1ps
module test_range_sample_and_motor_channels;
   import rsm_pkg::*;
   localparam int PCYC = 64;
   localparam int TICK_MHZ = 80;
   localparam int SYS_MHZ  = 25;
   logic        clock_in, rst_in, start_in, power_wr_in, sample_ready_in;
   logic        pulse, sample_valid_out, overflow_out, ok;
   logic [2:0]  gp_in, gv;
   logic [1:0]  enc_a_in, enc_b_in, pwm0, rev0, motor_pwm_out, motor_rev_out;
   logic [23:0] analog_in;
   logic [5:0]  motor1_level_out, motor2_level_out;
   logic [63:0] e;
   rsm_power_t  power1_in, power2_in;
   rsm_sample_t sample_out, got;
   int          num_errors, n_checks, pos1, pos2, ph1, ph2, d1, d2, w, n;
   int          h1, h2;
   rsm_sensor_model rsm_sensor_model_inst (.clock_in(clock_in),
      .pulse_out(pulse));
   rsm_top #(.PWM_CYC(PCYC)) rsm_top_inst (
      .clock_in(clock_in), .rst_in(rst_in), .range_pulse_in(pulse),
      .start_in(start_in), .gp_in(gp_in), .enc_a_in(enc_a_in),
      .enc_b_in(enc_b_in), .analog_in(analog_in), .power1_in(power1_in),
      .power2_in(power2_in), .power_wr_in(power_wr_in),
      .sample_ready_in(sample_ready_in), .sample_out(sample_out),
      .sample_valid_out(sample_valid_out), .motor_pwm_out(motor_pwm_out),
      .motor_rev_out(motor_rev_out), .motor1_level_out(motor1_level_out),
      .motor2_level_out(motor2_level_out), .overflow_out(overflow_out));
   // Voltage-only variant fed with the same stimulus
   rsm_top #(.PWM_OPTION(1'b0), .PWM_CYC(PCYC)) rsm_top_inst2 (
      .clock_in(clock_in), .rst_in(rst_in), .range_pulse_in(pulse),
      .start_in(start_in), .gp_in(gp_in), .enc_a_in(enc_a_in),
      .enc_b_in(enc_b_in), .analog_in(analog_in), .power1_in(power1_in),
      .power2_in(power2_in), .power_wr_in(power_wr_in),
      .sample_ready_in(sample_ready_in), .sample_out(),
      .sample_valid_out(), .motor_pwm_out(pwm0), .motor_rev_out(rev0),
      .motor1_level_out(), .motor2_level_out(), .overflow_out());
   // Free-running system clock
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      n_checks++;
      if (g !== x) begin
         num_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // Range count within one timing step of the model
   task automatic chk_rng(input logic [18:0] g, input int x);
      n_checks++;
      if ($isunknown(g) || g + 3 < x || g > x + 3) begin
         num_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Quadrature steps on both encoders, held long enough to sync
   task automatic step_enc(input int k);
      logic [1:0] g1, g2;
      repeat (k) begin
         ph1 = (ph1 + d1) & 3;
         ph2 = (ph2 + d2) & 3;
         pos1 -= d1; // B leading A counts down
         pos2 -= d2;
         g1 = 2'(ph1 ^ (ph1 >> 1));
         g2 = 2'(ph2 ^ (ph2 >> 1));
         @(posedge clock_in);
         enc_a_in <= {g2[1], g1[1]};
         enc_b_in <= {g2[0], g1[0]};
         repeat (3) @(posedge clock_in);
      end
   endtask
   // Take the head while ready is low, then pop it with one ready cycle
   task automatic read(output rsm_sample_t s, output logic v, input int b);
      int k;
      k = 0;
      @(negedge clock_in);
      while (sample_valid_out !== 1'b1 && k < b) begin
         @(negedge clock_in);
         k++;
      end
      v = (sample_valid_out === 1'b1);
      s = sample_out;
      if (v) begin
         @(posedge clock_in);
         sample_ready_in <= 1'b1;
         @(posedge clock_in);
         sample_ready_in <= 1'b0;
         repeat (2) @(negedge clock_in);
      end
   endtask
   initial begin
      num_errors = 0; n_checks = 0; pos1 = 0; pos2 = 0; ph1 = 0; ph2 = 0;
      rst_in = 1'b1; start_in = 1'b1; gp_in = 3'h0; analog_in = 24'h0;
      enc_a_in = 2'h0; enc_b_in = 2'h0; power_wr_in = 1'b0;
      power1_in = 7'h00; power2_in = 7'h00; sample_ready_in = 1'b0;
      void'($urandom(32'h6450));
      repeat (4) @(posedge clock_in);
      rst_in <= 1'b0;
      @(negedge clock_in);
      chk({motor1_level_out, motor2_level_out}, 12'h000);
      // Power write: motor 1 reversed, motor 2 forward
      @(posedge clock_in);
      power1_in <= 7'($urandom) | 7'h40;
      power2_in <= 7'($urandom) & 7'h3f;
      power_wr_in <= 1'b1;
      @(posedge clock_in);
      power_wr_in <= 1'b0;
      repeat (2) @(negedge clock_in);
      chk(motor1_level_out, power1_in.level);
      chk(motor2_level_out, power2_in.level);
      repeat (PCYC + 8) @(negedge clock_in);
      chk(motor_rev_out, 2'b01);
      chk({pwm0, rev0}, 4'h0);
      // Duty over one full period is level sixty-fourths of it
      h1 = 0;
      h2 = 0;
      repeat (PCYC) begin
         @(negedge clock_in);
         h1 += motor_pwm_out[0];
         h2 += motor_pwm_out[1];
      end
      chk(h1, power1_in.level * PCYC / 64);
      chk(h2, power2_in.level * PCYC / 64);
      // Samples at the slow sensor rate with encoders and index pulses
      for (int i = 0; i < 10; i++) begin
         d1 = ($urandom & 1) ? 1 : -1;
         d2 = -d1;
         gv = 3'($urandom);
         @(posedge clock_in);
         gp_in <= gv;
         analog_in <= 24'($urandom);
         step_enc(20 + $urandom % 60);
         gp_in <= {gv[2], 2'h0};
         repeat (4) @(posedge clock_in);
         w = 3 + $urandom % 40;
         rsm_sensor_model_inst.fire(w, 5000);
         read(got, ok, 20000);
         if (!ok) begin
            num_errors++;
            results();
         end
         e = {19'h0, 1'b0, ~gv[2], gv[1:0], 1'b1, analog_in,
              8'(pos1), 8'(pos2)};
         chk_rng(got.range_count, w * TICK_MHZ / SYS_MHZ);
         chk(64'(got[44:0]), 64'(e[44:0]));
      end
      // Pulse with sampling disabled is not stored
      @(posedge clock_in);
      start_in <= 1'b0;
      rsm_sensor_model_inst.fire(10, 500);
      @(negedge clock_in);
      chk(sample_valid_out, 1'b0);
      @(posedge clock_in);
      start_in <= 1'b1;
      // Back-to-back pulses at the fastest rate overrun the buffer
      for (int i = 0; i < 9; i++) rsm_sensor_model_inst.fire(10, 500);
      @(negedge clock_in);
      chk(overflow_out, 1'b1);
      n = 0;
      for (int i = 0; i < 10; i++) begin
         read(got, ok, 8);
         if (ok) n++;
      end
      chk(n, 8);
      results();
   end
endmodule // test_range_sample_and_motor_channels
